//--- core/lcdmp_buf.sv
// Two-entry buffer between the host port and the command/display consumer.
// Assumes the system clock and asynchronous active-low reset; all outputs come from flip-flops.
module lcdmp_buf
  import lcdmp_pkg::*;
(
  input  wire logic   clk_sys_i,
  input  wire logic   rstn_i,
  lcdmp_xfer_if.snk   in_if,
  lcdmp_xfer_if.src   out_if,
  output logic        ready_q_o
);

  logic        out_v_q;
  logic        out_v_d;
  lcdmp_word_s out_q;
  lcdmp_word_s out_d;
  logic        skid_v_q;
  logic        skid_v_d;
  lcdmp_word_s skid_q;
  lcdmp_word_s skid_d;
  logic        push;
  logic        out_free;

  assign push     = in_if.valid && ready_q_o;
  assign out_free = !out_v_q || out_if.ready;

  // The skid slot keeps a word that arrives while the consumer stalls.
  assign out_v_d  = out_free ? (skid_v_q || push) : 1'b1;
  assign out_d    = !out_free ? out_q : (skid_v_q ? skid_q : in_if.word);
  assign skid_v_d = out_free ? (skid_v_q && push) : (skid_v_q || push);
  assign skid_d   = push && (!out_free || skid_v_q) ? in_if.word : skid_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_v_q   <= 1'b0;
      out_q     <= '0;
      skid_v_q  <= 1'b0;
      skid_q    <= '0;
      ready_q_o <= 1'b1;
    end else begin
      out_v_q   <= out_v_d;
      out_q     <= out_d;
      skid_v_q  <= skid_v_d;
      skid_q    <= skid_d;
      ready_q_o <= !skid_v_d;
    end
  end

  assign in_if.ready  = ready_q_o;
  assign out_if.valid = out_v_q;
  assign out_if.word  = out_q;

endmodule

//--- core/lcdmp_host_port.sv
// Host-facing bus port of the display controller: 8080, 6800 and serial bus decoding.
// Assumes host pins are asynchronous to clk_sys_i; the serial shift clock is the same wire as
// data line 6 and is brought in on its own clock port; bidirectional lines are split into
// input, output and output enable, resolved outside.

// Operation
// (RQ1) The two straps select 8080 parallel (0/1), 6800 parallel (1/1), serial (1/0) or reset (0/0).
// (RQ2) In either parallel mode one whole byte moves per bus cycle on the eight data lines.
// (RQ3) In serial mode the shift clock is data line 6, the serial data is data line 7 and the byte path is ignored.
// (RQ4) In serial mode neither display data nor status is returned to the host.
// (RQ5) In serial mode data lines 0 to 5 are never driven.
// (RQ6) In serial mode the host keeps the read and write strobes at a steady level.
// (RQ7) For 6800 the host raises both straps together or the first strap before the second.
// (RQ8) With command/data select high a read gives display data and a write stores display data; low, a read gives status.
// (RQ9) A write with command/data select low is a command byte for the control registers.
// (RQ10) Transfers are accepted only while the low-active select is low and the high-active select is high.
// (RQ11) In 8080 mode the bus is driven only while the read strobe is low; in 6800 mode the access is qualified by enable high.
// (RQ12) In serial mode data is sampled on each rising shift clock, most significant bit first, eight bits to a byte.
// (RQ13) In serial mode command/data select is sampled on the eighth rising shift clock of each byte.
// (RQ14) While the straps select reset, the logic is held in reset and all transfers are ignored.
module lcdmp_host_port
  import lcdmp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        shift_clk_i,
  input  wire logic        interface_strap_first_i,
  input  wire logic        interface_strap_second_i,
  input  wire logic        chip_select_low_active_n_i,
  input  wire logic        chip_select_high_active_i,
  input  wire logic        command_data_select_i,
  input  wire logic        read_strobe_i,
  input  wire logic        write_strobe_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic      [7:0]  data_oe_o,
  input  wire logic [7:0]  display_data_i,
  input  wire logic [7:0]  status_i,
  output logic             display_read_o,
  output logic             out_valid_o,
  output logic      [7:0]  out_data_o,
  output logic             out_is_display_o,
  input  wire logic        out_ready_i,
  output logic             host_ready_o,
  output logic             core_reset_o,
  output lcdmp_mode_e      mode_o
);

  // ---------------- Serial shift clock domain ----------------
  logic                 ser_rstn;
  logic [SER_CNT_W-1:0] ser_cnt_q;
  logic [6:0]           ser_sh_q;
  logic [7:0]           ser_byte_q;
  logic                 ser_cd_q;
  logic                 ser_tog_q;
  logic                 ser_sel;
  logic                 ser_last;

  // Shift register and counter clear whenever the chip or the serial mode is deselected.
  assign ser_sel  = !chip_select_low_active_n_i && chip_select_high_active_i &&
                    interface_strap_first_i && !interface_strap_second_i;
  assign ser_rstn = rstn_i && ser_sel;

  always_ff @(posedge shift_clk_i or negedge ser_rstn) begin
    if (!ser_rstn) begin
      ser_sh_q <= '0;
    end else begin
      ser_sh_q <= {ser_sh_q[5:0], data_i[7]};  // [RQ3] [RQ12]
    end
  end

  always_ff @(posedge shift_clk_i or negedge ser_rstn) begin
    if (!ser_rstn) begin
      ser_cnt_q <= '0;
    end else begin
      ser_cnt_q <= ser_cnt_q + 3'h1;
    end
  end

  // Completed byte and its command/data flag are held until the next eighth edge.
  assign ser_last = ser_sel && (ser_cnt_q == SER_LAST);  // [RQ13]

  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_byte_q <= DATA_RST_VAL;
    end else if (ser_last) begin
      ser_byte_q <= {ser_sh_q, data_i[7]};  // [RQ12]
    end
  end

  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_cd_q <= 1'b0;
    end else if (ser_last) begin
      ser_cd_q <= command_data_select_i;  // [RQ13]
    end
  end

  always_ff @(posedge shift_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_tog_q <= 1'b0;
    end else if (ser_last) begin
      ser_tog_q <= !ser_tog_q;
    end
  end

  // ---------------- Pin synchronisers ----------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] st_q;
  logic [PIN_W-1:0] prev_q;

  assign pin_raw = {ser_tog_q, interface_strap_first_i, interface_strap_second_i,
                    chip_select_low_active_n_i, chip_select_high_active_i,
                    command_data_select_i, read_strobe_i, write_strobe_i, data_i};

  // A pin change is accepted once the second and third stages agree.
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        s1_q[i]   <= PIN_RST_VAL[i];
        s2_q[i]   <= PIN_RST_VAL[i];
        s3_q[i]   <= PIN_RST_VAL[i];
        st_q[i]   <= PIN_RST_VAL[i];
        prev_q[i] <= PIN_RST_VAL[i];
      end else begin
        s1_q[i]   <= pin_raw[i];
        s2_q[i]   <= s1_q[i];
        s3_q[i]   <= s2_q[i];
        st_q[i]   <= (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
        prev_q[i] <= st_q[i];
      end
    end
  end

  // ---------------- Decoding in the system domain ----------------
  lcdmp_mode_e mode;
  wire         selected   = !st_q[PIN_CSL_N] && st_q[PIN_CSH];  // [RQ10]
  wire         cd         = st_q[PIN_CD];
  wire         rd_now     = st_q[PIN_RD];
  wire         rd_was     = prev_q[PIN_RD];
  wire         wr_now     = st_q[PIN_WR];
  wire         wr_was     = prev_q[PIN_WR];
  wire  [7:0]  bus_byte   = st_q[PIN_DATA_LSB +: BYTE_W];
  wire         ser_event  = st_q[PIN_SER_TOG] != prev_q[PIN_SER_TOG];

  assign mode = lcdmp_mode_e'({st_q[PIN_STRAP_FST], st_q[PIN_STRAP_SEC]});  // [RQ1]

  wire is_8080   = (mode == LCDMP_MODE_I8080);
  wire is_6800   = (mode == LCDMP_MODE_M6800);
  wire is_serial = (mode == LCDMP_MODE_SERIAL);
  wire is_reset  = (mode == LCDMP_MODE_RESET);  // [RQ14]

  // In 8080 mode the read strobe is active low and the write byte is taken at write's rising edge.
  wire w8080_wr    = is_8080 && selected && !wr_was && wr_now;        // [RQ2] [RQ11]
  wire w8080_rdbeg = is_8080 && selected && rd_was && !rd_now;
  wire w8080_drive = is_8080 && selected && !rd_now;                  // [RQ11]

  // In 6800 mode the read strobe pin is enable and the write strobe pin is read/not-write.
  wire w6800_wr    = is_6800 && selected && rd_was && !rd_now && !wr_now;  // [RQ2] [RQ11]
  wire w6800_rdbeg = is_6800 && selected && !rd_was && rd_now && wr_now;
  wire w6800_drive = is_6800 && selected && rd_now && wr_now;             // [RQ11]

  // Serial bytes bypass the parallel path; the host's steady strobes are not looked at.
  wire wser        = is_serial && ser_event;  // [RQ3] [RQ6]

  wire par_write   = w8080_wr || w6800_wr;
  wire read_begin  = w8080_rdbeg || w6800_rdbeg;
  wire drive_bus   = w8080_drive || w6800_drive;  // [RQ4] [RQ5]

  // Read data: display data with the select high, status with it low.
  wire [7:0] rd_byte = cd ? display_data_i : status_i;  // [RQ8]

  // ---------------- Write path into the buffer ----------------
  lcdmp_xfer_if in_x ();
  lcdmp_xfer_if out_x ();

  logic        wv_q;
  logic        wv_d;
  lcdmp_word_s ww_q;
  lcdmp_word_s ww_d;
  logic [7:0]  ser_byte_sys_q;
  logic        ser_cd_sys_q;

  // A write with the select low is a command byte, high is display data.
  assign wv_d = !is_reset && (par_write || wser);  // [RQ14]
  assign ww_d = wser      ? '{is_display: ser_cd_sys_q, data: ser_byte_sys_q} :
                par_write ? '{is_display: cd, data: bus_byte} : ww_q;  // [RQ8] [RQ9]

  // The serial byte is stable for eight shift clocks after its toggle, so it is read here only
  // while the toggle is still travelling through the synchroniser.
  wire ser_grab = s2_q[PIN_SER_TOG] != st_q[PIN_SER_TOG];

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_byte_sys_q <= DATA_RST_VAL;
    end else if (ser_grab) begin
      ser_byte_sys_q <= ser_byte_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_cd_sys_q <= 1'b0;
    end else if (ser_grab) begin
      ser_cd_sys_q <= ser_cd_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wv_q <= 1'b0;
    end else begin
      wv_q <= wv_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ww_q <= '0;
    end else begin
      ww_q <= ww_d;
    end
  end

  assign in_x.valid = wv_q;
  assign in_x.word  = ww_q;
  assign out_x.ready = out_ready_i;

  lcdmp_buf u_buf (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .in_if     (in_x),
    .out_if    (out_x),
    .ready_q_o (host_ready_o)
  );

  assign out_valid_o      = out_x.valid;
  assign out_data_o       = out_x.word.data;
  assign out_is_display_o = out_x.word.is_display;

  // ---------------- Read path and bus drivers ----------------
  logic [7:0]  data_q;
  logic [7:0]  data_d;
  logic [7:0]  oe_q;
  logic [7:0]  oe_d;
  logic        drd_q;
  logic        drd_d;
  logic        core_rst_q;
  lcdmp_mode_e mode_q;

  // Lines 0 to 5 stay undriven in serial mode because drive_bus never holds there.
  assign oe_d   = (drive_bus && !is_reset) ? 8'hff : 8'h00;  // [RQ4] [RQ5] [RQ11]
  assign data_d = drive_bus ? rd_byte : data_q;              // [RQ2] [RQ8]
  assign drd_d  = read_begin && cd && !is_reset;             // [RQ8] [RQ14]

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_q <= DATA_RST_VAL;
    end else begin
      data_q <= data_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_q <= 8'h00;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drd_q <= 1'b0;
    end else begin
      drd_q <= drd_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= is_reset;  // [RQ14]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= LCDMP_MODE_RESET;
    end else begin
      mode_q <= mode;
    end
  end

  assign data_o         = data_q;
  assign data_oe_o      = oe_q;
  assign display_read_o = drd_q;
  assign core_reset_o   = core_rst_q;
  assign mode_o         = mode_q;

endmodule

//--- core/lcdmp_pkg.sv
// Package for the display controller host port: strap codes, pin sync layout and word type.
// Assumes a single system clock domain plus a separate serial shift clock domain.
package lcdmp_pkg;

  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned SER_CNT_W = 3;
  localparam logic [2:0]  SER_LAST  = 3'h7;

  // Interface modes, coded as {strap_first, strap_second}; Gray along reset, 8080, 6800, serial.
  typedef enum logic [1:0] {
    LCDMP_MODE_RESET  = 2'h0,
    LCDMP_MODE_I8080  = 2'h1,
    LCDMP_MODE_M6800  = 2'h3,
    LCDMP_MODE_SERIAL = 2'h2
  } lcdmp_mode_e;

  // Bit positions of the synchronised pin vector.
  localparam int unsigned PIN_DATA_LSB  = 0;
  localparam int unsigned PIN_WR        = 8;
  localparam int unsigned PIN_RD        = 9;
  localparam int unsigned PIN_CD        = 10;
  localparam int unsigned PIN_CSH       = 11;
  localparam int unsigned PIN_CSL_N     = 12;
  localparam int unsigned PIN_STRAP_SEC = 13;
  localparam int unsigned PIN_STRAP_FST = 14;
  localparam int unsigned PIN_SER_TOG   = 15;
  localparam int unsigned PIN_W         = 16;

  // Idle levels of the pins: strobes high, chip deselected, straps in reset.
  localparam logic [15:0] PIN_RST_VAL = 16'h1300;

  // Reset value of the data bus drivers and the serial byte registers.
  localparam logic [7:0] DATA_RST_VAL = 8'h00;

  typedef struct packed {
    logic       is_display;
    logic [7:0] data;
  } lcdmp_word_s;

endpackage

//--- core/lcdmp_xfer_if.sv
// Valid/ready carrier for bytes received from the host, between the port and its buffer.
// Assumes both ends run on the system clock.
interface lcdmp_xfer_if;
  import lcdmp_pkg::*;
  logic        valid;
  logic        ready;
  lcdmp_word_s word;

  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface

//--- verification/lcdmp_host_model.sv
// Host model: straps, selects, bus strobes and the serial link of the far side.
// Assumes the bench resolves the data wire and returns it on bus_i.
module lcdmp_host_model
  import lcdmp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] bus_i,
  output logic            sf_o,
  output logic            ss_o,
  output logic            csl_n_o,
  output logic            csh_o,
  output logic            cd_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] d_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sf_o, ss_o, csh_o, cd_o} = 4'h0;
    {csl_n_o, rd_o, wr_o} = 3'h7;
    d_o = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic sel(input logic lo, input logic hi);
    csl_n_o = !lo;
    csh_o = hi;
    cyc(8);
  endtask
  task automatic set_mode(input lcdmp_mode_e m);
    sel(1'b0, 1'b0);
    {sf_o, ss_o} = 2'h0;
    d_o = 8'h00;
    cyc(8);
    rd_o = (m != LCDMP_MODE_M6800);  // Strobes idle, and steady in serial mode.
    wr_o = 1'b1;
    sf_o = m[1];  // First strap settles before the second.
    cyc(2);
    ss_o = m[0];
    cyc(10);
    sel(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic m68, input logic is_rd, input logic cd, input logic [7:0] wd,
                      output logic [7:0] rv);
    cd_o = cd;
    d_o = is_rd ? ~d_o : wd;  // A released bus shows the inverse of its last value.
    if (m68) wr_o = is_rd;
    cyc(6);
    if (m68) rd_o = 1'b1;
    else if (is_rd) rd_o = 1'b0;
    else wr_o = 1'b0;
    cyc(10);
    rv = bus_i;
    if (m68) rd_o = 1'b0;
    else {rd_o, wr_o} = 2'h3;
    cyc(8);
    wr_o = 1'b1;
    d_o = ~d_o;
    cyc(1);
  endtask
  task automatic ser(input logic cd, input logic [7:0] b, input int n);
    #7;
    for (int i = 7; i > 7 - n; i--) begin
      d_o[7] = b[i];
      cd_o = (i == 0) ? cd : !cd;  // Only the eighth edge may decide the class.
      #24 d_o[6] = 1'b1;
      #24 d_o[6] = 1'b0;
    end
    cyc(8);
  endtask
endmodule

//--- verification/lcdmp_host_port_bench.sv
// Bench for the host port: host model cycles in, words drained at the buffer output.
// Assumes the package, the design, the host model and the checker are compiled first.
module lcdmp_host_port_bench
  import lcdmp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DISP = 8'h5a;
  localparam logic [7:0] STAT = 8'hc3;
  logic        clk, rstn, out_ready, out_valid, out_disp, disp_rd, host_ready, core_reset;
  logic        sf, ss, csl_n, csh, cd, rd, wr;
  logic [7:0]  h_d, bus, dut_d, dut_oe, out_data, rv;
  lcdmp_mode_e mode;
  int          bad_count = 0;
  int          tests_run = 0;
  int          rd_pulses = 0;
  assign bus = (dut_oe & dut_d) | (~dut_oe & h_d);
  // Display reads are counted so that every read pulse, and only those, is accounted for.
  always @(negedge clk) if (disp_rd === 1'b1) rd_pulses++;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  lcdmp_host_port i_lcdmp_host_port (.clk_sys_i(clk), .rstn_i(rstn), .shift_clk_i(bus[6]),
    .interface_strap_first_i(sf), .interface_strap_second_i(ss), .chip_select_low_active_n_i(csl_n),
    .chip_select_high_active_i(csh), .command_data_select_i(cd), .read_strobe_i(rd), .write_strobe_i(wr),
    .data_i(bus), .data_o(dut_d), .data_oe_o(dut_oe), .display_data_i(DISP), .status_i(STAT),
    .display_read_o(disp_rd), .out_valid_o(out_valid), .out_data_o(out_data), .out_is_display_o(out_disp),
    .out_ready_i(out_ready), .host_ready_o(host_ready), .core_reset_o(core_reset), .mode_o(mode));
  lcdmp_host_model i_lcdmp_host_model (.clk_sys_i(clk), .bus_i(bus), .sf_o(sf), .ss_o(ss), .csl_n_o(csl_n),
    .csh_o(csh), .cd_o(cd), .rd_o(rd), .wr_o(wr), .d_o(h_d));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic take(input logic [8:0] exp);
    int n;
    n = 0;
    while (out_valid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check("word", {out_valid, out_disp, out_data}, {1'b1, exp});
    out_ready = 1'b1;
    @(negedge clk);
    out_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic none();
    logic seen;
    seen = 1'b0;
    repeat (30) @(negedge clk) seen = seen | out_valid;
    check("no_word", {8'h0, seen}, 9'h0);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    out_ready = 1'b0;
    repeat (4) @(negedge clk);
    check("core_reset", {8'h0, core_reset}, 9'h1);
    rstn = 1'b1;
    for (int m = 0; m < 2; m++) begin
      i_lcdmp_host_model.set_mode(m[0] ? LCDMP_MODE_M6800 : LCDMP_MODE_I8080);
      check("mode", {7'h0, mode}, m[0] ? 9'h3 : 9'h1);
      i_lcdmp_host_model.xfer(m[0], 1'b0, 1'b1, 8'ha5, rv);
      take(9'h1a5);
      i_lcdmp_host_model.xfer(m[0], 1'b0, 1'b0, 8'h3c, rv);
      take(9'h03c);
      i_lcdmp_host_model.xfer(m[0], 1'b1, 1'b1, 8'h00, rv);
      check("rd_disp", {1'b0, rv}, {1'b0, DISP});
      i_lcdmp_host_model.xfer(m[0], 1'b1, 1'b0, 8'h00, rv);
      check("rd_stat", {1'b0, rv}, {1'b0, STAT});
      i_lcdmp_host_model.sel(1'b1, 1'b0);
      i_lcdmp_host_model.xfer(m[0], 1'b0, 1'b1, 8'h77, rv);
      none();
      i_lcdmp_host_model.sel(1'b0, 1'b1);
      i_lcdmp_host_model.xfer(m[0], 1'b1, 1'b1, 8'h00, rv);
      check("rd_off", {1'b0, rv}, 9'h077);
      i_lcdmp_host_model.sel(1'b1, 1'b1);
      check("rd_pulses", 10'(rd_pulses), 10'(m + 1));
      $display("test parallel %0d done", m);
    end
    for (int k = 1; k <= 3; k++) i_lcdmp_host_model.xfer(1'b1, 1'b0, 1'b1, 8'(k * 17), rv);
    check("host_ready", {8'h0, host_ready}, 9'h0);
    take(9'h111);
    take(9'h122);
    none();
    $display("test buffer done");
    i_lcdmp_host_model.set_mode(LCDMP_MODE_SERIAL);
    check("mode", {7'h0, mode}, 9'h2);
    i_lcdmp_host_model.ser(1'b1, 8'h96, 8);
    take(9'h196);
    i_lcdmp_host_model.ser(1'b0, 8'h41, 8);
    take(9'h041);
    i_lcdmp_host_model.ser(1'b1, 8'hff, 4);
    i_lcdmp_host_model.sel(1'b0, 1'b0);
    i_lcdmp_host_model.sel(1'b1, 1'b1);
    i_lcdmp_host_model.ser(1'b1, 8'h0f, 8);
    take(9'h10f);
    check("ser_oe", {1'b0, dut_oe}, 9'h0);
    $display("test serial done");
    i_lcdmp_host_model.set_mode(LCDMP_MODE_RESET);
    check("core_reset", {8'h0, core_reset}, 9'h1);
    i_lcdmp_host_model.xfer(1'b0, 1'b0, 1'b1, 8'h99, rv);
    none();
    $display("test reset mode done");
    complete_run();
  end
endmodule

//--- verification/lcdmp_host_port_props.sv
// Checker for the host port, watching only its top-level ports.
// Assumes the system clock domain; the serial link is judged by the bench.
module lcdmp_host_port_props
  import lcdmp_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        chip_select_low_active_n_i,
  input wire logic        chip_select_high_active_i,
  input wire logic        command_data_select_i,
  input wire logic        read_strobe_i,
  input wire logic        write_strobe_i,
  input wire logic [7:0]  display_data_i,
  input wire logic [7:0]  status_i,
  input wire logic [7:0]  data_o,
  input wire logic [7:0]  data_oe_o,
  input wire logic        display_read_o,
  input wire logic        out_valid_o,
  input wire logic [7:0]  out_data_o,
  input wire logic        out_is_display_o,
  input wire logic        out_ready_i,
  input wire logic        core_reset_o,
  input wire lcdmp_mode_e mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire        sel_on = !chip_select_low_active_n_i && chip_select_high_active_i;
  wire        rd_act = (mode_o == LCDMP_MODE_I8080) ? !read_strobe_i : (read_strobe_i && write_strobe_i);
  logic [4:0] idle_q;
  logic [3:0] rdcnt_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) idle_q <= 5'h00;
    else idle_q <= sel_on ? 5'h00 : (idle_q == 5'h1f ? idle_q : idle_q + 5'h01);
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) rdcnt_q <= 4'h0;
    else rdcnt_q <= !rd_act ? 4'h0 : (rdcnt_q == 4'hf ? rdcnt_q : rdcnt_q + 4'h1);
  oe_whole_a: assert property (data_oe_o == 8'h00 || data_oe_o == 8'hff)
    else $error("data enable split within the byte");
  serial_quiet_a: assert property (mode_o == LCDMP_MODE_SERIAL && $past(mode_o, 8) == LCDMP_MODE_SERIAL
    |-> data_oe_o == 8'h00) else $error("data lines driven in serial mode");
  reset_hold_a: assert property ((mode_o == LCDMP_MODE_RESET)[*3] |-> core_reset_o && data_oe_o == 8'h00)
    else $error("reset straps not holding the core");
  deselect_quiet_a: assert property (idle_q >= 5'h0a |-> data_oe_o == 8'h00)
    else $error("data lines driven while deselected");
  read_cause_a: assert property ($rose(data_oe_o[0]) |-> rdcnt_q >= 4'h3
    && (mode_o == LCDMP_MODE_I8080 || mode_o == LCDMP_MODE_M6800)) else $error("drive without read strobe");
  read_data_a: assert property (data_oe_o == 8'hff && $past(data_oe_o) == 8'hff && $stable(status_i)
    && $stable(display_data_i) && $stable(command_data_select_i)
    |-> data_o == (command_data_select_i ? display_data_i : status_i)) else $error("wrong read source");
  word_hold_a: assert property (out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(out_data_o) && $stable(out_is_display_o)) else $error("word dropped in stall");
  read_pulse_a: assert property (display_read_o
    |-> command_data_select_i && mode_o != LCDMP_MODE_SERIAL ##1 !display_read_o) else $error("bad read pulse");
endmodule

bind lcdmp_host_port lcdmp_host_port_props i_lcdmp_host_port_props (.clk_sys_i, .rstn_i,
  .chip_select_low_active_n_i, .chip_select_high_active_i, .command_data_select_i, .read_strobe_i,
  .write_strobe_i, .display_data_i, .status_i, .data_o, .data_oe_o, .display_read_o, .out_valid_o,
  .out_data_o, .out_is_display_o, .out_ready_i, .core_reset_o, .mode_o);
